// [hdl/mgs_pkg.sv]
`default_nettype none
package mgs_pkg;

  // register offsets, index space of the serial port
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] MODE0_OFFSET = 12'h001;

  // read-only virtual map rows, address bits 11:4
  localparam logic [7:0] VIRT_ROW_FIRST = 8'h80;
  localparam logic [7:0] VIRT_ROW_LAST = 8'h8f;
  localparam logic [7:0] SPECIAL_ROW = 8'hc0;

  // global_status field positions
  localparam int ST_CRYSTAL_FAILED = 6;
  localparam int ST_POWER_ON_RESET = 5;
  localparam int ST_WATCHDOG_RESET = 4;
  localparam int ST_CURRENT_ORDER = 3;
  localparam int ST_VOLTAGE_ORDER = 2;
  localparam int ST_SECOND_REVERSE = 1;
  localparam int ST_FIRST_REVERSE = 0;

  // operating_mode_0 field positions
  localparam int MD_EXTERNAL_CLOCK = 4;
  localparam int MD_SOFTWARE_RESTART = 3;
  localparam int MD_SIGNAL_DISABLE = 2;
  localparam int MD_LOW_POWER = 1;

  // reset values and writable mask
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MODE0_RESET = 8'h00;
  localparam logic [7:0] MODE0_WRITE_MASK = 8'h1e;

  // live status inputs, all on core_clk
  typedef struct packed {
    logic current_phase_order;
    logic voltage_phase_order;
    logic second_pulse_reverse;
    logic first_pulse_reverse;
  } mgs_status_in_t;

  // mode controls driven to the rest of the device
  typedef struct packed {
    logic external_clock_select;
    logic software_restart;
    logic signal_processing_disable;
    logic low_power_select;
  } mgs_mode_out_t;

endpackage : mgs_pkg
`default_nettype wire

// [hdl/mgs_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module mgs_regs (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // decoded serial-port register access
  input wire logic [11:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic host_wr_refused,
  // reset cause events, one-cycle pulses
  input wire logic power_on_reset_event,
  input wire logic watchdog_reset_event,
  // crystal monitor, asynchronous level
  input wire logic crystal_failed_pin,
  // live measurement status
  input wire mgs_pkg::mgs_status_in_t status_in,
  // software restart completion, one-cycle pulse
  input wire logic restart_done,
  // mode controls
  output mgs_pkg::mgs_mode_out_t mode_out
);

  logic crystal_failed_flag;
  logic power_on_reset_flag;
  logic watchdog_reset_flag;
  logic [3:0] live_status;
  logic [7:0] operating_mode_0;
  logic [7:0] next_mode;
  logic next_por;
  logic next_wdt;

  function automatic logic in_virtual_map(input logic [11:0] addr);
    in_virtual_map = (addr[11:4] >= mgs_pkg::VIRT_ROW_FIRST && addr[11:4] <= mgs_pkg::VIRT_ROW_LAST)
                     || addr[11:4] == mgs_pkg::SPECIAL_ROW;
  endfunction : in_virtual_map

  wire sel_status = host_addr == mgs_pkg::STATUS_OFFSET;
  wire sel_mode = host_addr == mgs_pkg::MODE0_OFFSET;
  wire sel_virtual = in_virtual_map(host_addr);
  wire wr_status = host_wr && sel_status;
  wire wr_mode = host_wr && sel_mode;
  wire [7:0] global_status = {1'b0, crystal_failed_flag, power_on_reset_flag, watchdog_reset_flag, live_status};
  wire [7:0] read_value = sel_status ? global_status : (sel_mode ? operating_mode_0 : 8'h00);

  mgs_sync3 u_crystal_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(crystal_failed_pin),
    .level_out(crystal_failed_flag)
  );

  assign next_por = power_on_reset_event
                    || (power_on_reset_flag && !(wr_status && !host_wdata[mgs_pkg::ST_POWER_ON_RESET]));
  assign next_wdt = watchdog_reset_event
                    || (watchdog_reset_flag && !(wr_status && !host_wdata[mgs_pkg::ST_WATCHDOG_RESET]));

  always_comb begin
    next_mode = operating_mode_0;
    if (wr_mode) begin
      next_mode = host_wdata & mgs_pkg::MODE0_WRITE_MASK;
    end
    if (restart_done && !(wr_mode && host_wdata[mgs_pkg::MD_SOFTWARE_RESTART])) begin
      next_mode[mgs_pkg::MD_SOFTWARE_RESTART] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      power_on_reset_flag <= mgs_pkg::STATUS_RESET[mgs_pkg::ST_POWER_ON_RESET];
      watchdog_reset_flag <= mgs_pkg::STATUS_RESET[mgs_pkg::ST_WATCHDOG_RESET];
      live_status <= mgs_pkg::STATUS_RESET[3:0];
      operating_mode_0 <= mgs_pkg::MODE0_RESET;
    end else if (clk_en) begin
      power_on_reset_flag <= next_por;
      watchdog_reset_flag <= next_wdt;
      live_status <= status_in;
      operating_mode_0 <= next_mode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
      host_wr_refused <= 1'b0;
    end else if (clk_en) begin
      host_rvalid <= host_rd;
      host_wr_refused <= host_wr && sel_virtual;
      if (host_rd) begin
        host_rdata <= read_value;
      end
    end
  end

  assign mode_out.external_clock_select = operating_mode_0[mgs_pkg::MD_EXTERNAL_CLOCK];
  assign mode_out.software_restart = operating_mode_0[mgs_pkg::MD_SOFTWARE_RESTART];
  assign mode_out.signal_processing_disable = operating_mode_0[mgs_pkg::MD_SIGNAL_DISABLE];
  assign mode_out.low_power_select = operating_mode_0[mgs_pkg::MD_LOW_POWER];

  // checks
  property p_virtual_read_only;
    @(posedge core_clk) disable iff (reset)
      clk_en && host_wr && sel_virtual && !restart_done |=> $stable(operating_mode_0) && host_wr_refused;
  endproperty
  a_virtual_read_only: assert property (p_virtual_read_only) else $error("virtual map write changed state");

  property p_crystal_follows;
    @(posedge core_clk) disable iff (reset)
      clk_en && crystal_failed_pin ##1 (clk_en && crystal_failed_pin) [*3] |=> crystal_failed_flag;
  endproperty
  a_crystal_follows: assert property (p_crystal_follows) else $error("crystal failure not reported");

  property p_por_set;
    @(posedge core_clk) disable iff (reset)
      clk_en && power_on_reset_event |=> power_on_reset_flag;
  endproperty
  a_por_set: assert property (p_por_set) else $error("power-on flag not set");

  property p_por_clear;
    @(posedge core_clk) disable iff (reset)
      clk_en && wr_status && !host_wdata[mgs_pkg::ST_POWER_ON_RESET] && !power_on_reset_event
      |=> !power_on_reset_flag;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on flag not cleared");

  property p_wdt_set_wins;
    @(posedge core_clk) disable iff (reset)
      clk_en && watchdog_reset_event |=> watchdog_reset_flag;
  endproperty
  a_wdt_set_wins: assert property (p_wdt_set_wins) else $error("watchdog flag lost");

  property p_wdt_clear;
    @(posedge core_clk) disable iff (reset)
      clk_en && wr_status && !host_wdata[mgs_pkg::ST_WATCHDOG_RESET] && !watchdog_reset_event
      |=> !watchdog_reset_flag;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog flag not cleared");

  property p_status_read;
    @(posedge core_clk) disable iff (reset)
      clk_en && host_rd && sel_status && $past(clk_en) && !$past(reset)
      |=> host_rvalid && host_rdata[3:0] == $past(status_in, 2) && !host_rdata[7];
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_mode_write;
    @(posedge core_clk) disable iff (reset)
      clk_en && wr_mode && !restart_done
      |=> mode_out == $past(host_wdata[4:1]) && operating_mode_0[7:5] == 3'h0 && !operating_mode_0[0];
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write not applied");

  property p_restart_clears;
    @(posedge core_clk) disable iff (reset)
      clk_en && restart_done && !wr_mode |=> !mode_out.software_restart;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart bit not cleared");

  property p_mode_holds;
    @(posedge core_clk) disable iff (reset)
      !clk_en || (!wr_mode && !restart_done) |=> $stable(operating_mode_0);
  endproperty
  a_mode_holds: assert property (p_mode_holds) else $error("mode changed without cause");

  property p_crystal_clears;
    @(posedge core_clk) disable iff (reset)
      clk_en && !crystal_failed_pin ##1 (clk_en && !crystal_failed_pin) [*3] |=> !crystal_failed_flag;
  endproperty
  a_crystal_clears: assert property (p_crystal_clears) else $error("crystal recovery not reported");

  property p_live_status;
    @(posedge core_clk) disable iff (reset)
      clk_en |=> live_status == $past(status_in);
  endproperty
  a_live_status: assert property (p_live_status) else $error("live status not tracking");

  property p_refused_only_virtual;
    @(posedge core_clk) disable iff (reset)
      clk_en && !(host_wr && sel_virtual) |=> !host_wr_refused;
  endproperty
  a_refused_only_virtual: assert property (p_refused_only_virtual) else $error("write refused outside map");

  property p_frozen;
    @(posedge core_clk) disable iff (reset)
      !clk_en |=> $stable(operating_mode_0) && $stable(power_on_reset_flag) && $stable(watchdog_reset_flag)
                  && $stable(host_rdata) && $stable(host_rvalid);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while disabled");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (reset)
      operating_mode_0[7:5] == 3'h0 && !operating_mode_0[0] && !global_status[7];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

endmodule : mgs_regs
`default_nettype wire

// [hdl/mgs_sync3.sv]
`timescale 1ns/100ps
`default_nettype none
module mgs_sync3 (
  // clock and control
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // asynchronous level in, filtered level out
  input wire logic async_in,
  output logic level_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // change accepted once second and third stages agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level_out <= 1'b0;
    end else if (clk_en) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_out <= stage3;
      end
    end
  end

endmodule : mgs_sync3
`default_nettype wire

// [verif/mgs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mgs_host_model (
  // clock
  input wire logic core_clk,
  // register port, host side
  output logic [11:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic host_wr_refused
);
  initial begin
    host_addr = 12'h000;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // one write, refusal sampled after it
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic refused);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
    @(posedge core_clk);
    refused = host_wr_refused;
  endtask : wr
  // one read, bounded wait for answer
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int n;
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (host_rvalid !== 1'b1 && n < 8);
    d = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
  endtask : rd
endmodule : mgs_host_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] wdata;
    logic [7:0] exp_mode;
    logic [3:0] live;
  } mgs_row_t;
  logic core_clk;
  logic reset;
  logic clk_en;
  logic [11:0] host_addr;
  logic host_wr;
  logic host_rd;
  logic [7:0] host_wdata;
  logic [7:0] host_rdata;
  logic host_rvalid;
  logic host_wr_refused;
  logic por_ev;
  logic wdt_ev;
  logic xtal_fail;
  logic restart_done;
  mgs_pkg::mgs_status_in_t status_in;
  mgs_pkg::mgs_mode_out_t mode_out;
  int fails;
  int n_checks;
  int cycles;
  logic [7:0] rv;
  logic refused;
  mgs_row_t rows [4];
  mgs_regs i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_wr_refused(host_wr_refused), .power_on_reset_event(por_ev),
    .watchdog_reset_event(wdt_ev), .crystal_failed_pin(xtal_fail), .status_in(status_in),
    .restart_done(restart_done), .mode_out(mode_out));
  mgs_host_model i_host (.core_clk(core_clk), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_wr_refused(host_wr_refused));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    {reset, clk_en, por_ev, wdt_ev, xtal_fail, restart_done} = 6'h30;
    status_in = 4'h0;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    rows = '{'{8'hff, 8'h1e, 4'ha}, '{8'h16, 8'h16, 4'h5}, '{8'h02, 8'h02, 4'hf}, '{8'h00, 8'h00, 4'h0}};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h00);
    i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
    chk("mode", rv, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      status_in <= rows[i].live;
      i_host.wr(mgs_pkg::MODE0_OFFSET, rows[i].wdata, refused);
      chk("mode_out", {4'h0, mode_out}, {4'h0, rows[i].exp_mode[4:1]});
      i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
      chk("mode", rv, rows[i].exp_mode);
      i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
      chk("status", rv, {4'h0, rows[i].live});
    end
    $display("test table done");
    @(posedge core_clk) por_ev <= 1'b1;
    @(posedge core_clk) por_ev <= 1'b0;
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h20);
    i_host.wr(mgs_pkg::STATUS_OFFSET, 8'hdf, refused);
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h00);
    @(posedge core_clk) wdt_ev <= 1'b1;
    @(posedge core_clk) wdt_ev <= 1'b0;
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h10);
    i_host.wr(mgs_pkg::STATUS_OFFSET, 8'hef, refused);
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h00);
    fork
      i_host.wr(mgs_pkg::STATUS_OFFSET, 8'h00, refused);
      begin
        @(posedge core_clk) por_ev <= 1'b1;
        @(posedge core_clk) por_ev <= 1'b0;
      end
    join
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h20);
    i_host.wr(mgs_pkg::STATUS_OFFSET, 8'h00, refused);
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h00);
    $display("test reset flags done");
    xtal_fail <= 1'b1;
    repeat (8) @(posedge core_clk);
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h40);
    xtal_fail <= 1'b0;
    repeat (8) @(posedge core_clk);
    i_host.rd(mgs_pkg::STATUS_OFFSET, rv);
    chk("status", rv, 8'h00);
    $display("test crystal done");
    i_host.wr(mgs_pkg::MODE0_OFFSET, 8'h08, refused);
    chk("mode_out", {4'h0, mode_out}, 8'h04);
    @(posedge core_clk) restart_done <= 1'b1;
    @(posedge core_clk) restart_done <= 1'b0;
    i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
    chk("mode", rv, 8'h00);
    $display("test restart done");
    i_host.wr(12'h801, 8'hff, refused);
    chk("refused", {7'h0, refused}, 8'h01);
    i_host.rd(12'h801, rv);
    chk("virtual", rv, 8'h00);
    i_host.wr(12'hc03, 8'hff, refused);
    chk("refused", {7'h0, refused}, 8'h01);
    i_host.wr(12'h005, 8'hff, refused);
    chk("refused", {7'h0, refused}, 8'h00);
    i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
    chk("mode", rv, 8'h00);
    $display("test virtual map done");
    clk_en <= 1'b0;
    i_host.wr(mgs_pkg::MODE0_OFFSET, 8'h1e, refused);
    chk("mode_out", {4'h0, mode_out}, 8'h00);
    i_host.wr(12'h801, 8'hff, refused);
    chk("refused", {7'h0, refused}, 8'h00);
    clk_en <= 1'b1;
    i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
    chk("mode", rv, 8'h00);
    $display("test clock enable done");
    i_host.wr(mgs_pkg::MODE0_OFFSET, 8'h1e, refused);
    i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
    chk("mode", rv, 8'h1e);
    reset <= 1'b1;
    @(posedge core_clk) reset <= 1'b0;
    @(posedge core_clk);
    chk("mode_out", {4'h0, mode_out}, 8'h00);
    chk("rdata", host_rdata, 8'h00);
    i_host.rd(mgs_pkg::MODE0_OFFSET, rv);
    chk("mode", rv, 8'h00);
    $display("test mid reset done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
